// ===== rtl/fesp_pkg.sv
package fesp_pkg;
   localparam int CLK_MHZ          = 125;
   localparam int CNT_W            = 16;
   // Bus timing in ns
   localparam int GLITCH_NS        = 5;
   localparam int SETUP_NS         = 10;
   localparam int WE_LOW_NS        = 40;
   localparam int HOLD_NS          = 10;
   localparam int READ_CYCLE_NS    = 90;
   localparam int GAP_NS           = 16;
   localparam int RESET_PULSE_NS   = 500;
   localparam int RESET_RELEASE_NS = 1000;
   localparam int SETTLE_NS        = 1000;
   // Cycle counts, least times rounded up
   localparam int SETUP_CYC        = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int WE_LOW_CYC       = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int GLITCH_CYC       = (GLITCH_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC         = (HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_CYC         = (READ_CYCLE_NS * CLK_MHZ + 999) / 1000;
   localparam int GAP_CYC          = (GAP_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_PULSE_CYC  = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_REL_CYC    = (RESET_RELEASE_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC       = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int SYNC_STAGES      = 2;
   // Command addresses and codes
   localparam logic [20:0] CMD_ADDR1      = 21'h000aaa;
   localparam logic [20:0] CMD_ADDR2      = 21'h000555;
   localparam logic [20:0] ID_MAKER_ADDR  = 21'h000000;
   localparam logic [20:0] ID_PART_ADDR   = 21'h000001;
   localparam logic [7:0]  CODE_UNLOCK1   = 8'haa;
   localparam logic [7:0]  CODE_UNLOCK2   = 8'h55;
   localparam logic [7:0]  CODE_PROGRAM   = 8'ha0;
   localparam logic [7:0]  CODE_ERASE_SET = 8'h80;
   localparam logic [7:0]  CODE_CHIP      = 8'h10;
   localparam logic [7:0]  CODE_SECTOR    = 8'h50;
   localparam logic [7:0]  CODE_BLOCK     = 8'h30;
   localparam logic [7:0]  CODE_SUSPEND   = 8'hb0;
   localparam logic [7:0]  CODE_RESUME    = 8'h30;
   localparam logic [7:0]  CODE_QUERY     = 8'h98;
   localparam logic [7:0]  CODE_SECID     = 8'h88;
   localparam logic [7:0]  CODE_SECID_PRG = 8'ha5;
   localparam logic [7:0]  CODE_ID_ENTRY  = 8'h90;
   localparam logic [7:0]  CODE_EXIT      = 8'hf0;
   // Boot block ranges
   localparam logic [20:0] BOOT_BOT_HI    = 21'h00ffff;
   localparam logic [20:0] BOOT_TOP_LO    = 21'h1f0000;
   localparam logic [1:0]  CONFIRM_READS  = 2'h2;
   localparam logic [2:0]  PROG_LEN       = 3'h4;
   localparam logic [2:0]  ERASE_LEN      = 3'h6;
   localparam logic [2:0]  ENTRY_LEN      = 3'h3;
   localparam logic [2:0]  SINGLE_LEN     = 3'h1;

   typedef enum logic [3:0] {
      OP_READ         = 4'h0,
      OP_PROGRAM      = 4'h1,
      OP_CHIP_ERASE   = 4'h2,
      OP_SECTOR_ERASE = 4'h3,
      OP_BLOCK_ERASE  = 4'h4,
      OP_ID_ENTRY     = 4'h5,
      OP_QUERY_ENTRY  = 4'h6,
      OP_SECID_ENTRY  = 4'h7,
      OP_EXIT         = 4'h8,
      OP_SUSPEND      = 4'h9,
      OP_RESUME       = 4'ha,
      OP_SECID_PROG   = 4'hb,
      OP_RESET        = 4'hc
   } fesp_op_t;

   typedef enum logic [1:0] {
      RES_OK      = 2'h0,
      RES_REFUSED = 2'h1,
      RES_TIMEOUT = 2'h2
   } fesp_result_t;
endpackage

// ===== rtl/fesp_cyc_if.sv
`timescale 1ns/10ps
interface fesp_cyc_if;
   logic        req;
   logic        wr;
   logic [20:0] addr;
   logic [7:0]  wdata;
   logic        done;
   logic [7:0]  rdata;
   modport ctrl (output req, output wr, output addr, output wdata, input done, input rdata);
   modport cyc  (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ===== rtl/fesp_cycle.sv
`timescale 1ns/10ps
module fesp_cycle
   import fesp_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   fesp_cyc_if.cyc          bus,
   input  wire logic [7:0]  flash_dq_in,
   output logic      [20:0] flash_addr,
   output logic      [7:0]  flash_dq_out,
   output logic             flash_dq_oe,
   output logic             flash_ce_n,
   output logic             flash_oe_n,
   output logic             flash_we_n
);
   typedef enum logic [2:0] {
      CY_IDLE   = 3'h0,
      CY_SETUP  = 3'h1,
      CY_STROBE = 3'h2,
      CY_HOLD   = 3'h3,
      CY_READ   = 3'h4,
      CY_GAP    = 3'h5
   } fesp_cyc_state_t;

   fesp_cyc_state_t   state;
   logic [CNT_W-1:0]  cnt;
   logic [7:0]        dq_s1;
   logic [7:0]        dq_s2;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dq_s1 <= 8'h00;
         dq_s2 <= 8'h00;
      end else begin
         dq_s1 <= flash_dq_in;
         dq_s2 <= dq_s1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state        <= CY_IDLE;
         cnt          <= '0;
         flash_addr   <= '0;
         flash_dq_out <= 8'h00;
         flash_dq_oe  <= 1'b0;
         flash_ce_n   <= 1'b1;
         flash_oe_n   <= 1'b1;
         flash_we_n   <= 1'b1;
         bus.done     <= 1'b0;
         bus.rdata    <= 8'h00;
      end else begin
         bus.done <= 1'b0;
         cnt      <= cnt + 1'b1;
         case (state)
            CY_IDLE: begin
               cnt <= '0;
               if (bus.req) begin
                  flash_addr <= bus.addr;
                  flash_ce_n <= 1'b0;
                  if (bus.wr) begin
                     flash_dq_out <= bus.wdata;
                     flash_dq_oe  <= 1'b1;
                     state        <= CY_SETUP;
                  end else begin
                     flash_oe_n <= 1'b0;
                     state      <= CY_READ;
                  end
               end
            end
            CY_SETUP: begin
               if (cnt == CNT_W'(SETUP_CYC - 1)) begin
                  flash_we_n <= 1'b0;
                  cnt        <= '0;
                  state      <= CY_STROBE;
               end
            end
            CY_STROBE: begin
               if (cnt == CNT_W'(WE_LOW_CYC - 1) && cnt >= CNT_W'(GLITCH_CYC)) begin
                  flash_we_n <= 1'b1;
                  cnt        <= '0;
                  state      <= CY_HOLD;
               end
            end
            CY_HOLD: begin
               if (cnt == CNT_W'(HOLD_CYC - 1)) begin
                  flash_ce_n  <= 1'b1;
                  flash_dq_oe <= 1'b0;
                  cnt         <= '0;
                  state       <= CY_GAP;
               end
            end
            CY_READ: begin
               if (cnt == CNT_W'(READ_CYC + SYNC_STAGES - 1)) begin
                  bus.rdata  <= dq_s2;
                  flash_ce_n <= 1'b1;
                  flash_oe_n <= 1'b1;
                  cnt        <= '0;
                  state      <= CY_GAP;
               end
            end
            CY_GAP: begin
               if (cnt == CNT_W'(GAP_CYC - 1)) begin
                  bus.done <= 1'b1;
                  state    <= CY_IDLE;
               end
            end
            default: begin
               state <= CY_IDLE;
            end
         endcase
      end
   end
endmodule

// ===== rtl/fesp_ctrl.sv
// Behaviour
// - Chip erase is six guarded writes ending with code 10H at AAAH.
// - After a program's bit 7 matches the data, wait 1 us before trusting the byte.
// - On an unsure status read, confirm with two further good reads.
// - Reset pulse aborts operations; interrupted ones must be reissued.
// - Program needs a three-write prefix, erase a five-write prefix.
// - Query mode is entered with three writes ending 98H at AAAH.
// - Security space is 256 bits in two unerasable 128-bit halves.
// - Security program completion uses toggle bits; entry ends 88H.
`timescale 1ns/10ps
module fesp_ctrl
   import fesp_pkg::*;
#(
   parameter int POLL_LIMIT = 200000
)
(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         cmd_valid,
   input  wire fesp_op_t     cmd_op,
   input  wire logic  [20:0] cmd_addr,
   input  wire logic  [7:0]  cmd_data,
   input  wire logic         protect_en,
   input  wire logic         protect_top,
   output logic              cmd_ready,
   output logic              rsp_valid,
   output logic       [7:0]  rsp_data,
   output fesp_result_t      rsp_result,
   input  wire logic  [7:0]  flash_dq_in,
   output logic       [20:0] flash_addr,
   output logic       [7:0]  flash_dq_out,
   output logic              flash_dq_oe,
   output logic              flash_ce_n,
   output logic              flash_oe_n,
   output logic              flash_we_n,
   output logic              flash_wp_n,
   output logic              flash_rst_n
);
   typedef enum logic [3:0] {
      ST_RST_LOW  = 4'h0,
      ST_RST_WAIT = 4'h1,
      ST_IDLE     = 4'h2,
      ST_SEQ      = 4'h3,
      ST_SEQ_WAIT = 4'h4,
      ST_POLL     = 4'h5,
      ST_POLL_WT  = 4'h6,
      ST_SETTLE   = 4'h7,
      ST_READ     = 4'h8,
      ST_READ_WT  = 4'h9,
      ST_RESP     = 4'ha
   } fesp_state_t;

   fesp_cyc_if        cyc ();
   fesp_state_t       state;
   fesp_op_t          op;
   logic [20:0]       op_addr;
   logic [7:0]        op_data;
   logic [2:0]        step;
   logic [CNT_W-1:0]  cnt;
   logic [31:0]       polls;
   logic [7:0]        prev;
   logic              have_prev;
   logic [1:0]        agree;
   logic              in_boot;
   logic              refuse;
   logic              stable;
   logic              is_erase;
   logic              is_prog;
   logic [28:0]       word;

   function automatic logic [2:0] seq_len(input fesp_op_t o);
      case (o)
         OP_PROGRAM, OP_SECID_PROG:                       seq_len = PROG_LEN;
         OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_BLOCK_ERASE:  seq_len = ERASE_LEN;
         OP_ID_ENTRY, OP_QUERY_ENTRY, OP_SECID_ENTRY:     seq_len = ENTRY_LEN;
         default:                                         seq_len = SINGLE_LEN;
      endcase
   endfunction

   function automatic logic [28:0] seq_word(input fesp_op_t o, input logic [2:0] s,
                                            input logic [20:0] a, input logic [7:0] d);
      logic [7:0]  third;
      logic        er;
      er = o inside {OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_BLOCK_ERASE};
      case (o)
         OP_PROGRAM:     third = CODE_PROGRAM;
         OP_SECID_PROG:  third = CODE_SECID_PRG;
         OP_QUERY_ENTRY: third = CODE_QUERY;
         OP_SECID_ENTRY: third = CODE_SECID;
         OP_ID_ENTRY:    third = CODE_ID_ENTRY;
         default:        third = CODE_ERASE_SET;
      endcase
      if (o == OP_EXIT) begin
         seq_word = {a, CODE_EXIT};
      end else if (o == OP_SUSPEND) begin
         seq_word = {a, CODE_SUSPEND};
      end else if (o == OP_RESUME) begin
         seq_word = {a, CODE_RESUME};
      end else begin
         case (s)
            3'h0:    seq_word = {CMD_ADDR1, CODE_UNLOCK1};
            3'h1:    seq_word = {CMD_ADDR2, CODE_UNLOCK2};
            3'h2:    seq_word = {CMD_ADDR1, third};
            3'h3:    seq_word = er ? {CMD_ADDR1, CODE_UNLOCK1} : {a, d};
            3'h4:    seq_word = {CMD_ADDR2, CODE_UNLOCK2};
            default: seq_word = (o == OP_CHIP_ERASE) ? {CMD_ADDR1, CODE_CHIP} :
                                {a, (o == OP_SECTOR_ERASE) ? CODE_SECTOR : CODE_BLOCK};
         endcase
      end
   endfunction

   always_comb begin
      in_boot = protect_top ? (cmd_addr >= BOOT_TOP_LO) : (cmd_addr <= BOOT_BOT_HI);
      refuse  = protect_en && ((cmd_op == OP_CHIP_ERASE) ||
                (in_boot && (cmd_op inside {OP_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE})));
   end

   always_comb begin
      is_erase = op inside {OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_BLOCK_ERASE};
      is_prog  = op inside {OP_PROGRAM, OP_SECID_PROG};
      word     = seq_word(op, step, op_addr, op_data);
      stable   = have_prev && (cyc.rdata[6] == prev[6]);
      if (op == OP_PROGRAM) begin
         stable = stable && (cyc.rdata[7] == op_data[7]);
      end else if (is_erase) begin
         stable = stable && cyc.rdata[7];
      end
   end

   // Pin held static during any command sequence
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flash_wp_n <= 1'b1;
      end else if (state == ST_IDLE && !cmd_valid) begin
         flash_wp_n <= !protect_en;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state       <= ST_RST_LOW;
         op          <= OP_READ;
         op_addr     <= '0;
         op_data     <= 8'h00;
         step        <= 3'h0;
         cnt         <= '0;
         polls       <= '0;
         prev        <= 8'h00;
         have_prev   <= 1'b0;
         agree       <= 2'h0;
         cmd_ready   <= 1'b0;
         rsp_valid   <= 1'b0;
         rsp_data    <= 8'h00;
         rsp_result  <= RES_OK;
         flash_rst_n <= 1'b0;
         cyc.req     <= 1'b0;
         cyc.wr      <= 1'b0;
         cyc.addr    <= '0;
         cyc.wdata   <= 8'h00;
      end else begin
         cyc.req   <= 1'b0;
         rsp_valid <= 1'b0;
         cnt       <= cnt + 1'b1;
         case (state)
            ST_RST_LOW: begin
               flash_rst_n <= 1'b0;
               if (cnt == CNT_W'(RESET_PULSE_CYC - 1)) begin
                  flash_rst_n <= 1'b1;
                  cnt         <= '0;
                  state       <= ST_RST_WAIT;
               end
            end
            ST_RST_WAIT: begin
               if (cnt == CNT_W'(RESET_REL_CYC - 1)) begin
                  cmd_ready <= 1'b1;
                  state     <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               cnt <= '0;
               if (cmd_valid) begin
                  op         <= cmd_op;
                  op_addr    <= cmd_addr;
                  op_data    <= cmd_data;
                  step       <= 3'h0;
                  cmd_ready  <= 1'b0;
                  rsp_data   <= 8'h00;
                  rsp_result <= RES_OK;
                  if (cmd_op == OP_RESET) begin
                     state <= ST_RST_LOW;
                  end else if (refuse) begin
                     rsp_result <= RES_REFUSED;
                     state      <= ST_RESP;
                  end else if (cmd_op == OP_READ) begin
                     state <= ST_READ;
                  end else begin
                     state <= ST_SEQ;
                  end
               end
            end
            ST_SEQ: begin
               cyc.req   <= 1'b1;
               cyc.wr    <= 1'b1;
               cyc.addr  <= word[28:8];
               cyc.wdata <= word[7:0];
               state     <= ST_SEQ_WAIT;
            end
            ST_SEQ_WAIT: begin
               if (cyc.done) begin
                  if (step == seq_len(op) - 3'h1) begin
                     polls     <= '0;
                     have_prev <= 1'b0;
                     agree     <= 2'h0;
                     state     <= (is_prog || is_erase) ? ST_POLL : ST_RESP;
                  end else begin
                     step  <= step + 3'h1;
                     state <= ST_SEQ;
                  end
               end
            end
            ST_POLL, ST_READ: begin
               cyc.req  <= 1'b1;
               cyc.wr   <= 1'b0;
               cyc.addr <= op_addr;
               state    <= (state == ST_POLL) ? ST_POLL_WT : ST_READ_WT;
            end
            ST_POLL_WT: begin
               if (cyc.done) begin
                  prev      <= cyc.rdata;
                  have_prev <= 1'b1;
                  rsp_data  <= cyc.rdata;
                  if (stable && agree == CONFIRM_READS) begin
                     cnt   <= '0;
                     state <= is_prog ? ST_SETTLE : ST_RESP;
                  end else if (polls == 32'(POLL_LIMIT - 1)) begin
                     rsp_result <= RES_TIMEOUT;
                     state      <= ST_RESP;
                  end else begin
                     agree <= stable ? agree + 2'h1 : 2'h0;
                     polls <= polls + 32'h1;
                     state <= ST_POLL;
                  end
               end
            end
            ST_SETTLE: begin
               if (cnt == CNT_W'(SETTLE_CYC - 1)) begin
                  state <= ST_READ;
               end
            end
            ST_READ_WT: begin
               if (cyc.done) begin
                  rsp_data <= cyc.rdata;
                  state    <= ST_RESP;
               end
            end
            ST_RESP: begin
               rsp_valid <= 1'b1;
               cmd_ready <= 1'b1;
               state     <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   fesp_cycle u_cycle (
      .mclk         (mclk),
      .rst          (rst),
      .bus          (cyc.cyc),
      .flash_dq_in  (flash_dq_in),
      .flash_addr   (flash_addr),
      .flash_dq_out (flash_dq_out),
      .flash_dq_oe  (flash_dq_oe),
      .flash_ce_n   (flash_ce_n),
      .flash_oe_n   (flash_oe_n),
      .flash_we_n   (flash_we_n)
   );
endmodule

// ===== bench/fesp_ctrl_asserts.sv
`timescale 1ns/10ps
module fesp_ctrl_asserts
   import fesp_pkg::*;
(
   input wire logic         mclk,
   input wire logic         rst,
   input wire logic         cmd_valid,
   input wire fesp_op_t     cmd_op,
   input wire logic  [20:0] cmd_addr,
   input wire logic         protect_en,
   input wire logic         protect_top,
   input wire logic         cmd_ready,
   input wire logic         rsp_valid,
   input wire fesp_result_t rsp_result,
   input wire logic  [7:0]  flash_dq_out,
   input wire logic  [20:0] flash_addr,
   input wire logic         flash_dq_oe,
   input wire logic         flash_ce_n,
   input wire logic         flash_oe_n,
   input wire logic         flash_we_n,
   input wire logic         flash_rst_n
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire taken = cmd_valid && cmd_ready;
   sequence s_we_pulse;
      !flash_we_n [*5] ##1 flash_we_n;
   endsequence
   sequence s_refused;
      flash_we_n [*3] ##0 (rsp_valid && rsp_result == RES_REFUSED);
   endsequence
   a_rst_hold: assert property ($fell(rst) |-> !flash_rst_n [*8] ##1 !cmd_ready [*8])
      else $error("flash reset released early");
   a_rst_quiet: assert property (!flash_rst_n |-> flash_we_n && flash_ce_n)
      else $error("strobe during flash reset");
   a_we_width: assert property ($fell(flash_we_n) |-> s_we_pulse)
      else $error("write strobe width wrong");
   a_write_gate: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
      else $error("write strobe without select");
   a_read_gate: assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe && flash_we_n)
      else $error("read overlaps a write");
   a_write_hold: assert property (!flash_we_n && !$fell(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
      else $error("bus moved during strobe");
   a_chip_refuse: assert property (taken && protect_en && cmd_op == OP_CHIP_ERASE |-> s_refused)
      else $error("protected chip erase not refused");
   a_boot_refuse: assert property (taken && protect_en && cmd_op == OP_PROGRAM &&
      (protect_top ? cmd_addr >= BOOT_TOP_LO : cmd_addr <= BOOT_BOT_HI) |-> s_refused)
      else $error("boot block program not refused");
   a_busy_ready: assert property (taken |=> !cmd_ready && !rsp_valid)
      else $error("ready while busy");
   a_resp_pulse: assert property (rsp_valid |-> cmd_ready ##1 !rsp_valid)
      else $error("response pulse wrong");
endmodule
bind fesp_ctrl fesp_ctrl_asserts u_asserts (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
   .cmd_addr(cmd_addr), .protect_en(protect_en), .protect_top(protect_top), .cmd_ready(cmd_ready),
   .rsp_valid(rsp_valid), .rsp_result(rsp_result), .flash_dq_out(flash_dq_out), .flash_addr(flash_addr),
   .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
   .flash_rst_n(flash_rst_n));

// ===== bench/fesp_flash_model.sv
`timescale 1ns/10ps
module fesp_flash_model
   import fesp_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'h3a, // Arbitrary
   parameter logic [7:0] PART_CODE  = 8'h4c, // Arbitrary
   parameter logic [7:0] SEC_CODE   = 8'h61, // Arbitrary
   parameter logic       TOP_BOOT   = 1'b0,
   parameter int         BUSY_POLLS = 6
)
(
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        rst_n,
   input  wire logic        wp_n,
   input  wire logic        hang,
   input  wire logic [20:0] addr,
   input  wire logic [7:0]  din,
   output logic      [7:0]  dout
);
   localparam logic [28:0] U1 = {CMD_ADDR1, CODE_UNLOCK1};
   localparam logic [28:0] U2 = {CMD_ADDR2, CODE_UNLOCK2};
   logic [7:0]  mem [logic [20:0]];
   logic [28:0] h [6] = '{default: '0};
   logic [7:0]  pd, v, rd = 8'h00;
   logic        sec, ers = 1'b0, tog = 1'b0, idm = 1'b0;
   int          busy = 0;
   realtime     t_fall, t_done = -1.0e6;
   function automatic logic prot(input logic [20:0] a);
      return !wp_n && (TOP_BOOT ? a >= BOOT_TOP_LO : a <= BOOT_BOT_HI);
   endfunction
   task automatic erase(input logic [20:0] a, input logic [20:0] m);
      foreach (mem[k]) if ((k & m) == (a & m)) mem[k] = 8'hff;
      busy = BUSY_POLLS;
      ers = 1'b1;
   endtask
   always @(negedge we_n) t_fall = $realtime;
   always @(posedge we_n) begin
      if (!ce_n && oe_n && rst_n && $realtime - t_fall >= 5.0 && busy == 0) begin
         for (int i = 0; i < 5; i++) h[i] = h[i + 1];
         h[5] = {addr, din};
         if (h[2] == U1 && h[3] == U2 && h[4][28:8] == CMD_ADDR1 && h[4][7:0] inside {CODE_PROGRAM, CODE_SECID_PRG}) begin
            sec = h[4][7:0] == CODE_SECID_PRG;
            pd = din;
            ers = 1'b0;
            if (!prot(addr)) begin
               if (!sec) mem[addr] = (mem.exists(addr) ? mem[addr] : 8'hff) & din;
               busy = BUSY_POLLS;
            end
            h[5] = '0;
         end else if (h[0] == U1 && h[1] == U2 && h[2] == {CMD_ADDR1, CODE_ERASE_SET} && h[3] == U1 && h[4] == U2) begin
            if (h[5] == {CMD_ADDR1, CODE_CHIP} && wp_n) erase(addr, 21'h0);
            else if (din == CODE_SECTOR && !prot(addr)) erase(addr, 21'h1ff000);
            else if (din == CODE_BLOCK && !prot(addr)) erase(addr, 21'h1f0000);
            h[5] = '0;
         end else if (h[3] == U1 && h[4] == U2 && h[5][28:8] == CMD_ADDR1 && din inside {CODE_ID_ENTRY, CODE_QUERY, CODE_SECID})
            idm = 1'b1;
         else if (din == CODE_EXIT) idm = 1'b0;
      end
   end
   always @(negedge oe_n) if (!ce_n) begin
      v = mem.exists(addr) ? mem[addr] : 8'hff;
      if (busy > 0) begin
         tog = ~tog;
         rd = ers ? {1'b0, tog, 3'h0, tog, 2'h0} : {sec ? pd[7] : ~pd[7], tog, 6'h2a};
         if (!hang) busy = busy - 1;
         if (busy == 0) t_done = $realtime;
      end else if (idm)
         rd = addr == ID_MAKER_ADDR ? MAKER_CODE : addr == ID_PART_ADDR ? PART_CODE : SEC_CODE;
      else
         rd = (!ers && $realtime - t_done < 1000.0) ? {v[7:6], ~v[5:0]} : v;
   end
   always @(negedge rst_n) begin
      busy = 0;
      idm = 1'b0;
   end
   assign dout = (!ce_n && !oe_n) ? rd : ~rd;
endmodule

// ===== bench/fesp_ctrl_tb.sv
`timescale 1ns/10ps
module fesp_ctrl_tb
   import fesp_pkg::*;
;
   localparam logic [7:0]  MAKER = 8'h3a; // Arbitrary
   localparam logic [7:0]  PART  = 8'h4c; // Arbitrary
   localparam logic [7:0]  SEC   = 8'h61; // Arbitrary
   localparam logic [20:0] A1    = 21'h000100;
   localparam logic [20:0] TA    = 21'h1f0000;
   localparam logic [20:0] CA    = CMD_ADDR1;
   typedef struct packed {
      fesp_op_t     op;
      logic [20:0]  a;
      logic [7:0]   d;
      logic         pe;
      logic         pt;
      fesp_result_t res;
      logic [7:0]   rd;
      logic         chk;
   } fesp_row_t;
   logic         mclk, rst, cmd_valid, protect_en, protect_top, cmd_ready, rsp_valid, hang;
   logic         flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_wp_n, flash_rst_n;
   logic [20:0]  cmd_addr, flash_addr;
   logic [7:0]   cmd_data, rsp_data, dq_in, mdl_dq, flash_dq_out;
   fesp_op_t     cmd_op;
   fesp_result_t rsp_result;
   int           err_total = 0;
   int           check_count = 0;
   fesp_row_t    rows [23] = '{
      '{OP_READ,A1,8'h0,0,0,RES_OK,8'hff,1}, '{OP_PROGRAM,A1,8'ha5,0,0,RES_OK,8'ha5,1},
      '{OP_PROGRAM,21'h200,8'h3c,1,0,RES_REFUSED,8'h0,0}, '{OP_PROGRAM,TA,8'h3c,1,1,RES_REFUSED,8'h0,0},
      '{OP_PROGRAM,TA,8'h5a,1,0,RES_OK,8'h5a,1}, '{OP_CHIP_ERASE,CA,8'h0,1,0,RES_REFUSED,8'h0,0},
      '{OP_ID_ENTRY,CA,8'h0,0,0,RES_OK,8'h0,0}, '{OP_READ,21'h0,8'h0,0,0,RES_OK,MAKER,1},
      '{OP_READ,21'h1,8'h0,0,0,RES_OK,PART,1}, '{OP_EXIT,A1,8'h0,0,0,RES_OK,8'h0,0},
      '{OP_READ,A1,8'h0,0,0,RES_OK,8'ha5,1}, '{OP_QUERY_ENTRY,CA,8'h0,0,0,RES_OK,8'h0,0},
      '{OP_SECID_ENTRY,CA,8'h0,0,0,RES_OK,8'h0,0}, '{OP_READ,21'h10,8'h0,0,0,RES_OK,SEC,1},
      '{OP_EXIT,A1,8'h0,0,0,RES_OK,8'h0,0}, '{OP_SECID_PROG,21'h10,8'h77,0,0,RES_OK,8'h0,0},
      '{OP_SECTOR_ERASE,TA,8'h0,0,0,RES_OK,8'h0,0}, '{OP_READ,TA,8'h0,0,0,RES_OK,8'hff,1},
      '{OP_BLOCK_ERASE,A1,8'h0,0,0,RES_OK,8'h0,0}, '{OP_SUSPEND,A1,8'h0,0,0,RES_OK,8'h0,0},
      '{OP_RESUME,A1,8'h0,0,0,RES_OK,8'h0,0}, '{OP_PROGRAM,21'h400,8'h81,0,0,RES_OK,8'h81,1},
      '{OP_CHIP_ERASE,CA,8'h0,0,0,RES_OK,8'h0,0}};
   assign dq_in = flash_dq_oe ? flash_dq_out : mdl_dq;
   fesp_ctrl #(.POLL_LIMIT(50)) DUT (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .protect_en(protect_en), .protect_top(protect_top),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_result(rsp_result),
      .flash_dq_in(dq_in), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
      .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_wp_n(flash_wp_n),
      .flash_rst_n(flash_rst_n));
   fesp_flash_model u_flash (.ce_n(flash_ce_n),
      .oe_n(flash_oe_n), .we_n(flash_we_n), .rst_n(flash_rst_n), .wp_n(flash_wp_n), .hang(hang),
      .addr(flash_addr), .din(flash_dq_out), .dout(mdl_dq));
   always #4 mclk = ~mclk;
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic send(input fesp_op_t op, input logic [20:0] a, input logic [7:0] d);
      int n = 0;
      while (cmd_ready !== 1'b1 && n < 3000) begin
         @(negedge mclk);
         n++;
      end
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
   endtask
   task automatic run(input fesp_op_t op, input logic [20:0] a, input logic [7:0] d, input logic pe, input logic pt);
      int n = 0;
      protect_en = pe;
      protect_top = pt;
      repeat (3) @(negedge mclk);
      send(op, a, d);
      while (rsp_valid !== 1'b1 && !(op == OP_RESET && cmd_ready === 1'b1) && n < 5000) begin
         @(negedge mclk);
         n++;
      end
      chk("completion", {7'h0, n < 5000}, 8'h01);
   endtask
   task automatic pulse_rst(input int n);
      rst = 1'b1;
      repeat (n) @(negedge mclk);
      chk("flash_rst_n", {7'h0, flash_rst_n}, 8'h00);
      chk("cmd_ready", {7'h0, cmd_ready}, 8'h00);
      rst = 1'b0;
   endtask
   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = OP_READ;
      cmd_addr = '0;
      cmd_data = '0;
      protect_en = 1'b0;
      protect_top = 1'b0;
      hang = 1'b0;
      pulse_rst(5);
      foreach (rows[i]) begin
         run(rows[i].op, rows[i].a, rows[i].d, rows[i].pe, rows[i].pt);
         chk("flash_wp_n", {7'h0, flash_wp_n}, {7'h0, !rows[i].pe});
         chk("rsp_result", {6'h0, rsp_result}, {6'h0, rows[i].res});
         if (rows[i].chk) chk("rsp_data", rsp_data, rows[i].rd);
      end
      run(OP_READ, 21'h400, 8'h0, 1'b0, 1'b0);
      chk("erased", rsp_data, 8'hff);
      hang = 1'b1;
      run(OP_CHIP_ERASE, CA, 8'h0, 1'b0, 1'b0);
      chk("timeout", {6'h0, rsp_result}, {6'h0, RES_TIMEOUT});
      hang = 1'b0;
      run(OP_RESET, A1, 8'h0, 1'b0, 1'b0);
      run(OP_READ, A1, 8'h0, 1'b0, 1'b0);
      chk("after_reset", rsp_data, 8'hff);
      send(OP_PROGRAM, 21'h300, 8'h3c);
      repeat (30) @(negedge mclk);
      pulse_rst(2);
      run(OP_READ, 21'h300, 8'h0, 1'b0, 1'b0);
      chk("aborted", rsp_data, 8'hff);
      conclude();
   end
   initial begin
      repeat (60000) @(posedge mclk);
      err_total++;
      conclude();
   end
endmodule
